// *** verilog/tmr_cfg.svh ***
// Register offsets, reset values and field positions of the temperature monitor
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define TMR_A_INT_TEMP      8'h00
`define TMR_A_INT_TEMP_M    8'h38
`define TMR_A_EXT1_TEMP     8'h01
`define TMR_A_EXT1_TEMP_M   8'h3A
`define TMR_A_STATUS        8'h02
`define TMR_A_STATUS_M      8'h34
`define TMR_A_CFG           8'h03
`define TMR_A_CFG_M         8'h09
`define TMR_A_RATE          8'h04
`define TMR_A_RATE_M        8'h0A
`define TMR_A_INT_HI        8'h05
`define TMR_A_INT_HI_M      8'h0B
`define TMR_A_INT_LO        8'h06
`define TMR_A_INT_LO_M      8'h0C
`define TMR_A_EXT1_HI       8'h07
`define TMR_A_EXT1_HI_M     8'h0D
`define TMR_A_EXT1_LO       8'h08
`define TMR_A_EXT1_LO_M     8'h0E
`define TMR_A_ONE_SHOT      8'h0F
`define TMR_A_EXT1_FRAC     8'h10
`define TMR_A_EXT1_FRAC_M   8'h3B
`define TMR_A_EXT1_HI_FR    8'h13
`define TMR_A_EXT1_LO_FR    8'h14
`define TMR_A_EXT2_HI       8'h15
`define TMR_A_EXT2_LO       8'h16
`define TMR_A_EXT2_HI_FR    8'h17
`define TMR_A_EXT2_LO_FR    8'h18
`define TMR_A_EXT1_CRIT     8'h19
`define TMR_A_EXT2_CRIT     8'h1A
`define TMR_A_FAULT         8'h1B
`define TMR_A_MASK          8'h1F
`define TMR_A_INT_CRIT      8'h20
`define TMR_A_CRIT_HYST     8'h21
`define TMR_A_CONSEC        8'h22
`define TMR_A_EXT2_TEMP     8'h23
`define TMR_A_EXT2_TEMP_M   8'h3C
`define TMR_A_EXT2_FRAC     8'h24
`define TMR_A_EXT2_FRAC_M   8'h3D

// ************************************************************
// Reset values
// ************************************************************
`define TMR_R_ZERO          8'h00
`define TMR_R_RATE          8'h06
`define TMR_R_HI_LIM        8'h55
`define TMR_R_LO_LIM        8'h80
`define TMR_R_CRIT_LIM      8'h64
`define TMR_R_CRIT_HYST     8'h0A
`define TMR_R_CONSEC        8'h70
`define TMR_FAULT_MARK      8'h80

// ************************************************************
// Field positions
// ************************************************************
`define TMR_CFG_MASK_ALL    7
`define TMR_CFG_COMP_MODE   5
`define TMR_CFG_APD         1
`define TMR_STS_HIGH        4
`define TMR_STS_LOW         3
`define TMR_STS_FAULT       2
`define TMR_STS_CRIT        1
`define TMR_CONSEC_ALERT    1
`define TMR_CONSEC_CRIT     4
`define TMR_FAULT_USED      8'h0E
`define TMR_MASK_USED       8'h0F

`endif

// *** verilog/tmr_pkg.sv ***
// Types shared by the temperature monitor register bank
package tmr_pkg;

    typedef enum logic [1:0]
    {
        TMR_CH_INT  = 2'h0,
        TMR_CH_EXT1 = 2'h1,
        TMR_CH_EXT2 = 2'h2,
        TMR_CH_EXT3 = 2'h3
    } tmr_chan_t;

    typedef logic [7:0] tmr_byte_t;

endpackage

// *** verilog/tmr_regs.sv ***
// Register bank, limit checking and diode fault handling of the temperature monitor
`timescale 1ns/1ns
`include "tmr_cfg.svh"

// What this block does
// - On open or short, store 80h as channel integer byte and set status fault.
// - Paired mode: opens reported per channel, a short reported on both channels.
// - Third external channel is measured with polarity reversed from the second.
// - Host reads and writes every mapped register according to its access type.
// - Unused mask register bits ignore writes and read back as zero; configuration and consecutive-alert store all eight bits.
// - Internal integer byte reads identically at 00h and 38h.
// - First external integer byte reads identically at 01h and 3Ah.
// - Status at 02h mirrors status at 34h.
// - One configuration register at 03h and 09h, reset zero.
// - Conversion rate aliased at 04h and 0Ah, reset 06h.
// - Internal high limit aliased at 05h and 0Bh, reset 55h.
// - Internal low limit aliased at 06h and 0Ch, reset 80h.
// - First external limits at 07h/0Dh, 08h/0Eh; fractions 13h, 14h reset zero.
// - Second external limits at 15h to 18h with integer and fraction resets.
// - Any write to 0Fh starts one update of all channels; nothing stored.
// - Fault register holds one flag per external channel, cleared by read.
// - Critical limits at 19h, 1Ah and 20h reset to 64h.
// - One critical hysteresis value, reset 0Ah, applies to all critical checks.
// - Consecutive-alert register sets high-limit count before alert and critical count before alarm, reset 70h.
// - Channel mask suppresses high and low limit alerts per channel, reset zero.
// - Second external integer at 23h/3Ch, fraction at 24h/3Dh.
// - Comparator mode holds high status through reads until alert deasserts.
module tmr_regs
(
    input  wire logic       SYS_CLK,
    input  wire logic       NRST,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    input  wire logic       MEAS_VALID,
    input  wire logic [1:0] MEAS_CH,
    input  wire logic [7:0] MEAS_INT,
    input  wire logic [7:0] MEAS_FRAC,
    input  wire logic       MEAS_OPEN,
    input  wire logic       MEAS_SHORT,
    input  wire logic [1:0] CONV_CH,
    output logic            CONV_START,
    output logic            BIAS_REVERSE,
    output logic      [7:0] UPDATE_RATE,
    output logic            ALERT_N,
    output logic            CRITICAL_ALARM_OUTPUT_N
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic at_or_above(input logic [15:0] a, input logic [15:0] b);
        at_or_above = $signed(a) >= $signed(b);
    endfunction

    function automatic logic hit(input logic [1:0] a, input logic [7:0] x, input logic [7:0] y);
        hit = REG_WR && ((REG_ADDR == x) || (REG_ADDR == y));
    endfunction

    // ************************************************************
    // Storage
    // ************************************************************
    tmr_pkg::tmr_byte_t temp_int_q [3];
    tmr_pkg::tmr_byte_t temp_frac_q [3];
    tmr_pkg::tmr_byte_t hi_lim_q [3];
    tmr_pkg::tmr_byte_t lo_lim_q [3];
    tmr_pkg::tmr_byte_t hi_fr_q [3];
    tmr_pkg::tmr_byte_t lo_fr_q [3];
    tmr_pkg::tmr_byte_t crit_lim_q [3];
    tmr_pkg::tmr_byte_t cfg_q;
    tmr_pkg::tmr_byte_t rate_q;
    tmr_pkg::tmr_byte_t hyst_q;
    tmr_pkg::tmr_byte_t consec_q;
    tmr_pkg::tmr_byte_t mask_q;
    tmr_pkg::tmr_byte_t status_q;
    tmr_pkg::tmr_byte_t status_d;
    tmr_pkg::tmr_byte_t fault_q;
    tmr_pkg::tmr_byte_t fault_d;
    tmr_pkg::tmr_byte_t rd_mux;
    logic [2:0]         hi_cnt_q [3];
    logic [2:0]         crit_cnt_q [3];
    logic [2:0]         alert_ch_q;
    logic [2:0]         crit_ch_q;

    // ************************************************************
    // Write decode
    // ************************************************************
    wire       wr_cfg      = hit(2'h0, `TMR_A_CFG, `TMR_A_CFG_M);
    wire       wr_rate     = hit(2'h0, `TMR_A_RATE, `TMR_A_RATE_M);
    wire       wr_hyst     = hit(2'h0, `TMR_A_CRIT_HYST, `TMR_A_CRIT_HYST);
    wire       wr_consec   = hit(2'h0, `TMR_A_CONSEC, `TMR_A_CONSEC);
    wire       wr_mask     = hit(2'h0, `TMR_A_MASK, `TMR_A_MASK);
    wire       wr_oneshot  = hit(2'h0, `TMR_A_ONE_SHOT, `TMR_A_ONE_SHOT);
    wire [2:0] wr_hi;
    wire [2:0] wr_lo;
    wire [2:0] wr_crit;
    wire [2:0] wr_hi_fr;
    wire [2:0] wr_lo_fr;

    assign wr_hi[0]    = hit(2'h0, `TMR_A_INT_HI, `TMR_A_INT_HI_M);
    assign wr_lo[0]    = hit(2'h0, `TMR_A_INT_LO, `TMR_A_INT_LO_M);
    assign wr_hi[1]    = hit(2'h0, `TMR_A_EXT1_HI, `TMR_A_EXT1_HI_M);
    assign wr_lo[1]    = hit(2'h0, `TMR_A_EXT1_LO, `TMR_A_EXT1_LO_M);
    assign wr_hi[2]    = hit(2'h0, `TMR_A_EXT2_HI, `TMR_A_EXT2_HI);
    assign wr_lo[2]    = hit(2'h0, `TMR_A_EXT2_LO, `TMR_A_EXT2_LO);
    assign wr_hi_fr[0] = 1'b0;
    assign wr_lo_fr[0] = 1'b0;
    assign wr_hi_fr[1] = hit(2'h0, `TMR_A_EXT1_HI_FR, `TMR_A_EXT1_HI_FR);
    assign wr_lo_fr[1] = hit(2'h0, `TMR_A_EXT1_LO_FR, `TMR_A_EXT1_LO_FR);
    assign wr_hi_fr[2] = hit(2'h0, `TMR_A_EXT2_HI_FR, `TMR_A_EXT2_HI_FR);
    assign wr_lo_fr[2] = hit(2'h0, `TMR_A_EXT2_LO_FR, `TMR_A_EXT2_LO_FR);
    assign wr_crit[0]  = hit(2'h0, `TMR_A_INT_CRIT, `TMR_A_INT_CRIT);
    assign wr_crit[1]  = hit(2'h0, `TMR_A_EXT1_CRIT, `TMR_A_EXT1_CRIT);
    assign wr_crit[2]  = hit(2'h0, `TMR_A_EXT2_CRIT, `TMR_A_EXT2_CRIT);

    // ************************************************************
    // Read clear decode
    // ************************************************************
    wire rd_status = REG_RD && ((REG_ADDR == `TMR_A_STATUS) || (REG_ADDR == `TMR_A_STATUS_M));
    wire rd_fault  = REG_RD && (REG_ADDR == `TMR_A_FAULT);
    wire comp_mode = cfg_q[`TMR_CFG_COMP_MODE];
    wire apd_mode  = cfg_q[`TMR_CFG_APD];

    // ************************************************************
    // Measurement and fault decode
    // ************************************************************
    wire       is_fault    = MEAS_VALID && (MEAS_OPEN || MEAS_SHORT);
    wire       pair_ch     = (MEAS_CH == tmr_pkg::TMR_CH_EXT2) || (MEAS_CH == tmr_pkg::TMR_CH_EXT3);
    wire       pair_short  = MEAS_VALID && MEAS_SHORT && apd_mode && pair_ch;
    wire [3:0] ch_onehot   = 4'h1 << MEAS_CH;
    wire [3:0] fault_set   = (is_fault ? ch_onehot : 4'h0) | (pair_short ? 4'hC : 4'h0);
    wire [7:0] fault_bits  = {4'h0, fault_set} & `TMR_FAULT_USED;
    wire [2:0] alert_need  = consec_q[`TMR_CONSEC_ALERT +: 3];
    wire [2:0] crit_need   = consec_q[`TMR_CONSEC_CRIT +: 3];
    wire [15:0] cur_val    = {MEAS_INT, MEAS_FRAC};

    wire [2:0] meas_ok;
    wire [2:0] hi_hit;
    wire [2:0] lo_hit;
    wire [2:0] crit_hit;
    wire [2:0] hi_rel;
    wire [2:0] crit_rel;
    wire [2:0] hi_qual;
    wire [2:0] crit_qual;

    genvar c;
    generate
        for (c = 0; c < 3; c = c + 1)
        begin : g_chk
            wire [7:0] hi_back   = hi_lim_q[c] - hyst_q;
            wire [7:0] crit_back = crit_lim_q[c] - hyst_q;
            assign meas_ok[c]   = MEAS_VALID && !is_fault && (MEAS_CH == 2'(c));
            assign hi_hit[c]    = meas_ok[c] && at_or_above(cur_val, {hi_lim_q[c], hi_fr_q[c]});
            assign lo_hit[c]    = meas_ok[c] && !at_or_above(cur_val, {lo_lim_q[c], lo_fr_q[c]});
            assign crit_hit[c]  = meas_ok[c] && at_or_above(cur_val, {crit_lim_q[c], 8'h00});
            assign hi_rel[c]    = meas_ok[c] && !at_or_above(cur_val, {hi_back, hi_fr_q[c]});
            assign crit_rel[c]  = meas_ok[c] && !at_or_above(cur_val, {crit_back, 8'h00});
            assign hi_qual[c]   = hi_hit[c] && (hi_cnt_q[c] >= alert_need);
            assign crit_qual[c] = crit_hit[c] && (crit_cnt_q[c] >= crit_need);
        end
    endgenerate

    wire [2:0] unmasked   = ~mask_q[2:0];
    wire [2:0] alert_ch_d = (alert_ch_q | hi_qual) & ~(hi_rel & ~hi_qual);
    wire [2:0] crit_ch_d  = (crit_ch_q | crit_qual) & ~(crit_rel & ~crit_qual);
    wire       alert_any  = |(alert_ch_d & unmasked);
    wire       set_high   = |(hi_qual & unmasked);
    wire       set_low    = |(lo_hit & unmasked);
    wire       set_crit   = |crit_qual;

    // ************************************************************
    // Status update: set wins over read clear
    // ************************************************************
    wire       hold_high  = comp_mode && alert_any;
    wire       auto_clr   = comp_mode && !alert_any && !set_high;
    wire [7:0] sts_keep   = rd_status ? (hold_high ? (8'h1 << `TMR_STS_HIGH) : 8'h00) : 8'hFF;
    wire [7:0] sts_set    = ({7'h00, set_high} << `TMR_STS_HIGH)
                          | ({7'h00, set_low} << `TMR_STS_LOW)
                          | ({7'h00, |fault_set} << `TMR_STS_FAULT)
                          | ({7'h00, set_crit} << `TMR_STS_CRIT);
    wire [7:0] sts_raw    = (status_q & sts_keep) | sts_set;
    wire [7:0] sts_high_m = 8'h1 << `TMR_STS_HIGH;

    assign status_d = auto_clr ? (sts_raw & ~sts_high_m) : sts_raw;
    assign fault_d  = (rd_fault ? 8'h00 : fault_q) | fault_bits;

    wire       irq_level  = !cfg_q[`TMR_CFG_MASK_ALL] && (status_q != 8'h00);
    wire       alert_pin  = comp_mode ? alert_any : irq_level;

    // ************************************************************
    // Read selection
    // ************************************************************
    always_comb
    begin
        case (REG_ADDR)
            `TMR_A_INT_TEMP, `TMR_A_INT_TEMP_M:   rd_mux = temp_int_q[0];
            `TMR_A_EXT1_TEMP, `TMR_A_EXT1_TEMP_M: rd_mux = temp_int_q[1];
            `TMR_A_EXT1_FRAC, `TMR_A_EXT1_FRAC_M: rd_mux = temp_frac_q[1];
            `TMR_A_EXT2_TEMP, `TMR_A_EXT2_TEMP_M: rd_mux = temp_int_q[2];
            `TMR_A_EXT2_FRAC, `TMR_A_EXT2_FRAC_M: rd_mux = temp_frac_q[2];
            `TMR_A_STATUS, `TMR_A_STATUS_M:       rd_mux = status_q;
            `TMR_A_CFG, `TMR_A_CFG_M:             rd_mux = cfg_q;
            `TMR_A_RATE, `TMR_A_RATE_M:           rd_mux = rate_q;
            `TMR_A_INT_HI, `TMR_A_INT_HI_M:       rd_mux = hi_lim_q[0];
            `TMR_A_INT_LO, `TMR_A_INT_LO_M:       rd_mux = lo_lim_q[0];
            `TMR_A_EXT1_HI, `TMR_A_EXT1_HI_M:     rd_mux = hi_lim_q[1];
            `TMR_A_EXT1_LO, `TMR_A_EXT1_LO_M:     rd_mux = lo_lim_q[1];
            `TMR_A_EXT1_HI_FR:                    rd_mux = hi_fr_q[1];
            `TMR_A_EXT1_LO_FR:                    rd_mux = lo_fr_q[1];
            `TMR_A_EXT2_HI:                       rd_mux = hi_lim_q[2];
            `TMR_A_EXT2_LO:                       rd_mux = lo_lim_q[2];
            `TMR_A_EXT2_HI_FR:                    rd_mux = hi_fr_q[2];
            `TMR_A_EXT2_LO_FR:                    rd_mux = lo_fr_q[2];
            `TMR_A_EXT1_CRIT:                     rd_mux = crit_lim_q[1];
            `TMR_A_EXT2_CRIT:                     rd_mux = crit_lim_q[2];
            `TMR_A_INT_CRIT:                      rd_mux = crit_lim_q[0];
            `TMR_A_FAULT:                         rd_mux = fault_q;
            `TMR_A_MASK:                          rd_mux = mask_q;
            `TMR_A_CRIT_HYST:                     rd_mux = hyst_q;
            `TMR_A_CONSEC:                        rd_mux = consec_q;
            default:                              rd_mux = 8'h00;
        endcase
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            cfg_q    <= `TMR_R_ZERO;
            rate_q   <= `TMR_R_RATE;
            hyst_q   <= `TMR_R_CRIT_HYST;
            consec_q <= `TMR_R_CONSEC;
            mask_q   <= `TMR_R_ZERO;
        end
        else
        begin
            if (wr_cfg)    cfg_q    <= REG_WDATA;
            if (wr_rate)   rate_q   <= REG_WDATA;
            if (wr_hyst)   hyst_q   <= REG_WDATA;
            if (wr_consec) consec_q <= REG_WDATA;
            if (wr_mask)   mask_q   <= REG_WDATA & `TMR_MASK_USED;
        end
    end

    // ************************************************************
    // Limit registers
    // ************************************************************
    always_ff @(posedge SYS_CLK)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!NRST)
            begin
                hi_lim_q[i]   <= `TMR_R_HI_LIM;
                lo_lim_q[i]   <= `TMR_R_LO_LIM;
                hi_fr_q[i]    <= `TMR_R_ZERO;
                lo_fr_q[i]    <= `TMR_R_ZERO;
                crit_lim_q[i] <= `TMR_R_CRIT_LIM;
            end
            else
            begin
                if (wr_hi[i])    hi_lim_q[i]   <= REG_WDATA;
                if (wr_lo[i])    lo_lim_q[i]   <= REG_WDATA;
                if (wr_hi_fr[i]) hi_fr_q[i]    <= REG_WDATA;
                if (wr_lo_fr[i]) lo_fr_q[i]    <= REG_WDATA;
                if (wr_crit[i])  crit_lim_q[i] <= REG_WDATA;
            end
        end
    end

    // ************************************************************
    // Readings, integer byte forced to the marker on a fault
    // ************************************************************
    always_ff @(posedge SYS_CLK)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!NRST)
            begin
                temp_int_q[i]  <= `TMR_R_ZERO;
                temp_frac_q[i] <= `TMR_R_ZERO;
            end
            else if (fault_set[i])
            begin
                temp_int_q[i]  <= `TMR_FAULT_MARK;
            end
            else if (MEAS_VALID && (MEAS_CH == 2'(i)))
            begin
                temp_int_q[i]  <= MEAS_INT;
                temp_frac_q[i] <= MEAS_FRAC;
            end
        end
    end

    // ************************************************************
    // Consecutive counters and channel alarm states
    // ************************************************************
    always_ff @(posedge SYS_CLK)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!NRST)
            begin
                hi_cnt_q[i]   <= 3'h0;
                crit_cnt_q[i] <= 3'h0;
            end
            else if (MEAS_VALID && (MEAS_CH == 2'(i)))
            begin
                hi_cnt_q[i]   <= !hi_hit[i] ? 3'h0 : (&hi_cnt_q[i] ? 3'h7 : hi_cnt_q[i] + 3'h1);
                crit_cnt_q[i] <= !crit_hit[i] ? 3'h0
                               : (&crit_cnt_q[i] ? 3'h7 : crit_cnt_q[i] + 3'h1);
            end
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            alert_ch_q <= 3'h0;
            crit_ch_q  <= 3'h0;
            status_q   <= `TMR_R_ZERO;
            fault_q    <= `TMR_R_ZERO;
        end
        else
        begin
            alert_ch_q <= alert_ch_d;
            crit_ch_q  <= crit_ch_d;
            status_q   <= status_d;
            fault_q    <= fault_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            REG_RDATA               <= 8'h00;
            CONV_START              <= 1'b0;
            BIAS_REVERSE            <= 1'b0;
            UPDATE_RATE             <= `TMR_R_RATE;
            ALERT_N                 <= 1'b1;
            CRITICAL_ALARM_OUTPUT_N <= 1'b1;
        end
        else
        begin
            if (REG_RD)
                REG_RDATA <= rd_mux;
            CONV_START              <= wr_oneshot;
            BIAS_REVERSE            <= (CONV_CH == tmr_pkg::TMR_CH_EXT3);
            UPDATE_RATE             <= rate_q;
            ALERT_N                 <= !alert_pin;
            CRITICAL_ALARM_OUTPUT_N <= !(|crit_ch_d);
        end
    end

endmodule // tmr_regs

// *** tb/tmr_regs_props.sv ***
// Port-level checks of the temperature monitor register bank
`timescale 1ns/1ns
module tmr_regs_props
(
    input wire logic       SYS_CLK,
    input wire logic       NRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic       MEAS_VALID,
    input wire logic [1:0] MEAS_CH,
    input wire logic       MEAS_OPEN,
    input wire logic [1:0] CONV_CH,
    input wire logic       CONV_START,
    input wire logic       BIAS_REVERSE
);
    // ********************
    // Assertions
    // ********************
    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    property p_start; REG_WR && REG_ADDR == 8'h0F |=> CONV_START; endproperty
    a_start: assert property (p_start) else $error("no start pulse");
    property p_no_start; !(REG_WR && REG_ADDR == 8'h0F) |=> !CONV_START; endproperty
    a_no_start: assert property (p_no_start) else $error("stray start pulse");
    property p_bias_on; CONV_CH == 2'h3 |=> BIAS_REVERSE; endproperty
    a_bias_on: assert property (p_bias_on) else $error("bias not reversed");
    property p_bias_off; CONV_CH != 2'h3 |=> !BIAS_REVERSE; endproperty
    a_bias_off: assert property (p_bias_off) else $error("bias wrongly reversed");
    property p_hold; !REG_RD |=> $stable(REG_RDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_zero; REG_RD && REG_ADDR inside {8'h0F, 8'h11} |=> REG_RDATA == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("empty address not zero");
    property p_mask; REG_RD && REG_ADDR == 8'h1F |=> REG_RDATA[7:4] == 4'h0; endproperty
    a_mask: assert property (p_mask) else $error("unused mask bits set");
    property p_mark;
        MEAS_VALID && MEAS_CH == 2'h1 && MEAS_OPEN ##[1:4] REG_RD && REG_ADDR == 8'h01
        |=> REG_RDATA == 8'h80;
    endproperty
    a_mark: assert property (p_mark) else $error("fault marker missing");
    c_start: cover property (REG_WR && REG_ADDR == 8'h0F);
    c_bias: cover property (CONV_CH == 2'h3);
    c_fault: cover property (MEAS_VALID && MEAS_OPEN);
endmodule // tmr_regs_props

// *** tb/tmr_host_model.sv ***
// Register bus host issuing byte writes and reads
`timescale 1ns/1ns
module tmr_host_model
(
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd
);
    // ********************
    // Bus cycles
    // ********************
    initial
    begin
        addr  = 8'h00;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
endmodule // tmr_host_model

// *** tb/tmr_regs_tb.sv ***
// Self-checking bench of the temperature monitor register bank
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
`define RD(a, e) begin host.rd_byte(a, rv); `CHK(rv, e) end
module tmr_regs_tb;
    // ********************
    // Stimulus and checks
    // ********************
    logic       sys_clk = 1'b0;
    logic       nrst    = 1'b0;
    logic       mvalid  = 1'b0;
    logic       mopen   = 1'b0;
    logic       mshort  = 1'b0;
    logic [1:0] mch     = 2'h0;
    logic [1:0] cch     = 2'h0;
    logic [7:0] mint    = 8'h00;
    logic [7:0] mfrac   = 8'h00;
    logic [7:0] addr, wdata, rdata, rv, upd_rate;
    logic       wr, rd, conv_start, bias, alert_n, crit_n;
    int         err_total = 0;
    int         n_tests   = 0;
    int         cyc       = 0;
    logic [15:0] rst_rows [33] = '{16'h0000, 16'h3800, 16'h0100, 16'h3A00, 16'h0200,
        16'h3400, 16'h0300, 16'h0900, 16'h0406, 16'h0A06, 16'h0555, 16'h0B55, 16'h0680,
        16'h0C80, 16'h0755, 16'h0D55, 16'h0880, 16'h0E80, 16'h1300, 16'h1555, 16'h1680,
        16'h1800, 16'h1964, 16'h1A64, 16'h1B00, 16'h1F00, 16'h2064, 16'h210A, 16'h2270,
        16'h2400, 16'h3C00, 16'h0F00, 16'h1100};
    logic [31:0] wr_rows [13] = '{32'h03020902, 32'h0A050405, 32'h0B3C053C, 32'h06110C11,
        32'h0D410741, 32'h08900E90, 32'h13A513A5, 32'h16F016F0, 32'h21072107,
        32'h1FFF1F0F, 32'h005A0000, 32'h11771100, 32'h0F330F00};
    always #25 sys_clk = ~sys_clk;
    tmr_host_model host (.clk(sys_clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));
    tmr_regs uut (.SYS_CLK(sys_clk), .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .MEAS_VALID(mvalid), .MEAS_CH(mch),
        .MEAS_INT(mint), .MEAS_FRAC(mfrac), .MEAS_OPEN(mopen), .MEAS_SHORT(mshort),
        .CONV_CH(cch), .CONV_START(conv_start), .BIAS_REVERSE(bias),
        .UPDATE_RATE(upd_rate), .ALERT_N(alert_n), .CRITICAL_ALARM_OUTPUT_N(crit_n));
    task automatic end_of_test;
        if (err_total == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic meas(input logic [1:0] c, input logic [7:0] i, f, input logic o, s);
        @(posedge sys_clk);
        mvalid <= 1'b1;
        mch    <= c;
        mint   <= i;
        mfrac  <= f;
        mopen  <= o;
        mshort <= s;
        @(posedge sys_clk);
        mvalid <= 1'b0;
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            $display("[ERR] %0t timeout", $time);
            end_of_test();
        end
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        foreach (rst_rows[i])
            `RD(rst_rows[i][15:8], rst_rows[i][7:0])
        `CHK(upd_rate, 8'h06)
        foreach (wr_rows[i])
        begin
            host.wr_byte(wr_rows[i][31:24], wr_rows[i][23:16]);
            `RD(wr_rows[i][15:8], wr_rows[i][7:0])
        end
        `CHK(upd_rate, 8'h05)
        host.wr_byte(8'h0F, 8'h00);
        #1;
        `CHK(conv_start, 1'b1)
        meas(2'h1, 8'h2A, 8'h60, 1'b1, 1'b0);
        `RD(8'h01, 8'h80)
        `RD(8'h3A, 8'h80)
        `RD(8'h34, 8'h04)
        `RD(8'h02, 8'h00)
        `RD(8'h1B, 8'h02)
        `RD(8'h1B, 8'h00)
        meas(2'h2, 8'h00, 8'h00, 1'b0, 1'b1);
        `RD(8'h1B, 8'h0C)
        `RD(8'h3C, 8'h80)
        meas(2'h3, 8'h00, 8'h00, 1'b1, 1'b0);
        `RD(8'h1B, 8'h08)
        meas(2'h0, 8'h19, 8'h00, 1'b0, 1'b0);
        `RD(8'h38, 8'h19)
        meas(2'h2, 8'h20, 8'h40, 1'b0, 1'b0);
        `RD(8'h23, 8'h20)
        `RD(8'h3D, 8'h40)
        @(posedge sys_clk);
        cch <= 2'h3;
        @(posedge sys_clk);
        cch <= 2'h0;
        #1;
        `CHK(bias, 1'b1)
        `CHK(alert_n, 1'b0)
        `RD(8'h02, 8'h04)
        @(posedge sys_clk);
        #1;
        `CHK(alert_n, 1'b1)
        host.wr_byte(8'h22, 8'h00);
        host.wr_byte(8'h20, 8'h1E);
        meas(2'h0, 8'h20, 8'h00, 1'b0, 1'b0);
        #1;
        `CHK(crit_n, 1'b0)
        meas(2'h0, 8'h18, 8'h00, 1'b0, 1'b0);
        #1;
        `CHK(crit_n, 1'b0)
        meas(2'h0, 8'h16, 8'h00, 1'b0, 1'b0);
        #1;
        `CHK(crit_n, 1'b1)
        host.wr_byte(8'h03, 8'h22);
        meas(2'h0, 8'h40, 8'h00, 1'b0, 1'b0);
        #1;
        `CHK(alert_n, 1'b1)
        host.wr_byte(8'h1F, 8'h00);
        meas(2'h0, 8'h40, 8'h00, 1'b0, 1'b0);
        #1;
        `CHK(alert_n, 1'b0)
        `RD(8'h02, 8'h12)
        `RD(8'h02, 8'h10)
        meas(2'h0, 8'h30, 8'h00, 1'b0, 1'b0);
        #1;
        `CHK(alert_n, 1'b1)
        `RD(8'h34, 8'h02)
        end_of_test();
    end
endmodule // tmr_regs_tb
bind tmr_regs tmr_regs_props u_props (.SYS_CLK(SYS_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEAS_VALID(MEAS_VALID),
    .MEAS_CH(MEAS_CH), .MEAS_OPEN(MEAS_OPEN), .CONV_CH(CONV_CH), .CONV_START(CONV_START),
    .BIAS_REVERSE(BIAS_REVERSE));
